// ==== sshp_pkg.sv ====
// Package for the serial SRAM select/hold port: opcodes, widths, carriers
package sshp_pkg;
  localparam int          SSHP_OP_W      = 8;
  localparam int          SSHP_ADDR_W    = 16;
  localparam int          SSHP_DATA_W    = 8;
  localparam logic [7:0]  SSHP_OP_READ   = 8'h03;
  localparam logic [7:0]  SSHP_OP_WRITE  = 8'h02;
  localparam logic [7:0]  SSHP_OP_SRD    = 8'h05;
  localparam logic [7:0]  SSHP_OP_SWR    = 8'h01;
  localparam logic [15:0] SSHP_ADDR_MASK = 16'h7FFF;
  localparam logic [7:0]  SSHP_STAT_RST  = 8'h00;
  localparam logic [2:0]  SSHP_BIT_RST   = 3'h7;
  localparam int          SSHP_SYNC_W    = 2;
  localparam int          SSHP_FIFO_D    = 8;

  typedef enum logic [2:0] {
    SSHP_OPCODE,
    SSHP_ADDR,
    SSHP_RDATA,
    SSHP_WDATA,
    SSHP_SRD,
    SSHP_SWR,
    SSHP_IGNORE
  } sshp_state_t;

  // Write request to the memory side
  typedef struct packed {
    logic [14:0] addr;
    logic [7:0]  data;
  } sshp_wreq_t;
endpackage

// ==== sshp_fifo.sv ====
// Parameterised valid/ready FIFO with registered read data
`timescale 1ns/1ps
`default_nettype none
module sshp_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem_q [D];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0]   cnt_q;
  logic          push;
  logic          pop;

  // Count is one bit wider than the pointers so a full queue stays distinct from an empty one
  assign in_ready = (cnt_q != (AW+1)'(D));
  assign push     = in_valid && in_ready;
  // Read data register holds the head; valid when loaded
  assign pop      = (!out_valid || out_ready) && (cnt_q != '0);

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wp_q] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wp_q      <= '0;
      rp_q      <= '0;
      cnt_q     <= '0;
      out_valid <= 1'b0;
      out_data  <= '0;
    end else begin
      if (push) begin
        wp_q <= (wp_q == AW'(D - 1)) ? '0 : wp_q + 1'b1;
      end
      if (pop) begin
        rp_q     <= (rp_q == AW'(D - 1)) ? '0 : rp_q + 1'b1;
        out_data <= mem_q[rp_q];
      end
      if (pop) begin
        out_valid <= 1'b1;
      end else if (out_ready) begin
        out_valid <= 1'b0;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

// ==== sshp_port.sv ====
// Serial SRAM select/hold port: pin sampling, command decode, output driver
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Low select picks the device; high select puts it in standby.
// - A write in flight when select rises still completes.
// - Serial output is high impedance while select is high.
// - Input bits are captured on rising serial clock edges.
// - Serial output changes only after falling serial clock edges.
// - Pause high for normal use; pause low suspends without reset.
// - Pause with clock low acts now; with clock high, at next fall.
// - Paused: output high impedance, clock and input ignored.
// - Falling pause forces output high impedance at once.
// - Sequence opens with eight-bit read, write, status read or write.
// - Everything shifts most significant bit first.
// - Memory commands take a 16-bit address, top bit ignored.
// - After pause, transfer resumes at the same bit position.
module sshp_port
  import sshp_pkg::*;
#(
  parameter int FIFO_DEPTH = SSHP_FIFO_D
) (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic             cs_n,
  input  wire logic             sck,
  input  wire logic             si,
  input  wire logic             hold_n,
  output logic                  so_o,
  output logic                  so_oe,
  output logic                  wr_valid,
  input  wire logic             wr_ready,
  output sshp_wreq_t            wr_req,
  output logic                  rd_req,
  output logic [14:0]           rd_addr,
  input  wire logic [7:0]       rd_data,
  output logic [7:0]            status_q,
  output logic                  busy
);
  logic [SSHP_SYNC_W-1:0] cs_s_q, sck_s_q, si_s_q, hold_s_q;
  logic        sck_d1_q;
  logic        rise, fall;
  logic        sel;
  logic        paused_q;
  sshp_state_t st_q;
  logic [2:0]  bit_q;
  logic [7:0]  sh_q;
  logic [3:0]  abyte_q;
  logic [7:0]  op_q;
  logic [15:0] addr_q;
  logic [7:0]  out_q;
  logic        fifo_ready;
  logic        wv_q;
  sshp_wreq_t  wq_q;
  logic [7:0]  sh_d;
  logic        byte_done;
  logic        fetch_q;
  logic        pushed_q;
  logic        oe_arm_q;

  // Phases in which the serial output carries data
  function automatic logic drives_out(input sshp_state_t s);
    return (s == SSHP_RDATA) || (s == SSHP_SRD);
  endfunction

  // Two flops on every pin before any logic reads them
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cs_s_q   <= '1;
      sck_s_q  <= '0;
      si_s_q   <= '0;
      hold_s_q <= '1;
      sck_d1_q <= 1'b0;
    end else begin
      cs_s_q   <= {cs_s_q[0], cs_n};
      sck_s_q  <= {sck_s_q[0], sck};
      si_s_q   <= {si_s_q[0], si};
      hold_s_q <= {hold_s_q[0], hold_n};
      sck_d1_q <= sck_s_q[1];
    end
  end

  assign sel  = !cs_s_q[1];
  assign rise = sel && !paused_q && sck_s_q[1] && !sck_d1_q;
  assign fall = sck_d1_q && !sck_s_q[1];
  assign sh_d = {sh_q[6:0], si_s_q[1]};
  assign byte_done = rise && (bit_q == 3'h0);

  // Pause entry: clock low acts now, clock high waits for the fall; exit with clock low, or at once on deselect
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      paused_q <= 1'b0;
    end else if (!sel) begin
      paused_q <= 1'b0;
    end else if (!hold_s_q[1] && (!sck_s_q[1] || fall)) begin
      paused_q <= 1'b1;
    end else if (hold_s_q[1] && !sck_s_q[1]) begin
      paused_q <= 1'b0;
    end
  end

  // Sequence state; kept as is while paused so transfer resumes in place
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q    <= SSHP_OPCODE;
      bit_q   <= SSHP_BIT_RST;
      sh_q    <= '0;
      abyte_q <= '0;
      op_q    <= '0;
      addr_q  <= '0;
    end else if (!sel) begin
      st_q    <= SSHP_OPCODE;
      bit_q   <= SSHP_BIT_RST;
      abyte_q <= '0;
    end else if (rise) begin
      sh_q  <= sh_d;
      bit_q <= bit_q - 3'h1;
      if (byte_done) begin
        unique case (st_q)
          SSHP_OPCODE: begin
            op_q <= sh_d;
            unique case (sh_d)
              SSHP_OP_READ, SSHP_OP_WRITE: st_q <= SSHP_ADDR;
              SSHP_OP_SRD:                 st_q <= SSHP_SRD;
              SSHP_OP_SWR:                 st_q <= SSHP_SWR;
              default:                     st_q <= SSHP_IGNORE;
            endcase
          end
          SSHP_ADDR: begin
            addr_q  <= {addr_q[7:0], sh_d};
            abyte_q <= abyte_q + 4'h1;
            if (abyte_q == 4'h1) begin
              st_q <= (op_q == SSHP_OP_READ) ? SSHP_RDATA : SSHP_WDATA;
            end
          end
          SSHP_RDATA, SSHP_WDATA: addr_q <= (addr_q + 16'h1) & SSHP_ADDR_MASK;
          SSHP_SWR:    st_q <= SSHP_IGNORE;
          SSHP_SRD,
          SSHP_IGNORE: st_q <= st_q;
        endcase
      end
    end
  end

  // Status register written by the status write command
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      status_q <= SSHP_STAT_RST;
    end else if (sel && byte_done && st_q == SSHP_SWR) begin
      status_q <= sh_d;
    end
  end

  // Completed data bytes are queued; queue drains even after deselect
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wv_q <= 1'b0;
      wq_q <= '0;
    end else if (sel && byte_done && st_q == SSHP_WDATA) begin
      wv_q <= 1'b1;
      wq_q <= '{addr: addr_q[14:0], data: sh_d};
    end else if (fifo_ready) begin
      wv_q <= 1'b0;
    end
  end

  sshp_fifo #(
    .W (SSHP_ADDR_W - 1 + SSHP_DATA_W),
    .D (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rstn      (rstn),
    .in_valid  (wv_q),
    .in_ready  (fifo_ready),
    .in_data   (wq_q),
    .out_valid (wr_valid),
    .out_ready (wr_ready),
    .out_data  (wr_req)
  );

  // Fetch right after the byte-closing rise: the shifter loads at the next fall,
  // so the memory gets a few clocks instead of none
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fetch_q <= 1'b0;
      rd_req  <= 1'b0;
      rd_addr <= '0;
    end else begin
      fetch_q <= byte_done && ((st_q == SSHP_RDATA) ||
                 ((st_q == SSHP_ADDR) && (abyte_q == 4'h1) && (op_q == SSHP_OP_READ)));
      rd_req  <= sel && fetch_q;
      rd_addr <= addr_q[14:0];
    end
  end

  // A byte just pushed sits one clock in the queue before it shows as valid
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pushed_q <= 1'b0;
      busy     <= 1'b0;
    end else begin
      pushed_q <= wv_q && fifo_ready;
      busy     <= sel || wv_q || pushed_q || wr_valid;
    end
  end

  // Output byte loaded at the first fall of each byte, shifted on later falls
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      out_q <= '0;
      so_o  <= 1'b0;
      so_oe <= 1'b0;
    end else begin
      if (fall && sel && !paused_q) begin
        if (bit_q == SSHP_BIT_RST) begin
          so_o  <= (st_q == SSHP_SRD) ? status_q[7] : rd_data[7];
          out_q <= (st_q == SSHP_SRD) ? {status_q[6:0], 1'b0} : {rd_data[6:0], 1'b0};
        end else begin
          so_o  <= out_q[7];
          out_q <= {out_q[6:0], 1'b0};
        end
      end
      if (!sel || !hold_s_q[1] || paused_q) begin
        so_oe <= 1'b0;
      end else if ((fall || oe_arm_q) && drives_out(st_q)) begin
        so_oe <= 1'b1;
      end
    end
  end

  // Remembers that this frame's output was live, so a released pause drives it again
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      oe_arm_q <= 1'b0;
    end else if (!sel) begin
      oe_arm_q <= 1'b0;
    end else if (fall && !paused_q && drives_out(st_q)) begin
      oe_arm_q <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ==== sshp_monitor.sv ====
// Pin-level checker for the select/hold port
`timescale 1ns/1ps
`default_nettype none
module sshp_monitor
  import sshp_pkg::*;
(
  input wire logic       clk,
  input wire logic       rstn,
  input wire logic       cs_n,
  input wire logic       sck,
  input wire logic       hold_n,
  input wire logic       so_o,
  input wire logic       so_oe,
  input wire logic       wr_valid,
  input wire logic       wr_ready,
  input wire sshp_wreq_t wr_req,
  input wire logic       rd_req,
  input wire logic [7:0] status_q,
  input wire logic       busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // Four cycles cover the two-flop pin sync plus the output register
  a_oe_standby: assert property (cs_n [*4] |-> !so_oe) else $error("output on while deselected");
  a_oe_paused: assert property (!hold_n [*4] |-> !so_oe) else $error("output on while paused");
  a_pause_hiz: assert property ($fell(hold_n) |-> ##[0:3] !so_oe) else $error("pause left output on");
  a_so_fall: assert property (so_oe && $past(so_oe) && $changed(so_o) |-> !$past(sck, 2))
    else $error("output moved away from a falling edge");
  a_rd_pulse: assert property (rd_req |=> !rd_req) else $error("read request longer than one cycle");
  a_busy_sel: assert property (!cs_n [*4] |-> busy) else $error("not busy while selected");
  a_wr_pend: assert property (wr_valid |-> busy) else $error("write pending but idle");
  a_wr_hold: assert property (wr_valid && !wr_ready |=> wr_valid && $stable(wr_req))
    else $error("stalled write dropped or changed");
  a_stat_idle: assert property (cs_n [*4] |=> $stable(status_q)) else $error("status moved in standby");
  c_read: cover property (rd_req);
  c_stall: cover property (wr_valid && !wr_ready);
  c_pause: cover property (!hold_n && !cs_n);
endmodule
bind sshp_port sshp_monitor mon (.clk(clk), .rstn(rstn), .cs_n(cs_n), .sck(sck), .hold_n(hold_n), .so_o(so_o),
  .so_oe(so_oe), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_req(wr_req), .rd_req(rd_req),
  .status_q(status_q), .busy(busy));
`default_nettype wire

// ==== sshp_host.sv ====
// Serial host model: select, serial clock, data in and pause
`timescale 1ns/1ps
`default_nettype none
module sshp_host (
  input  wire logic clk,
  input  wire logic so_o,
  input  wire logic so_oe,
  output logic      cs_n,
  output logic      sck,
  output logic      si,
  output logic      hold_n
);
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    hold_n = 1'b1;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Data line flips on deselect so a stale bit is never mistaken for a live one
  task automatic sel(input logic v);
    @(posedge clk);
    cs_n <= v;
    if (v) si <= ~si;
    cyc(4);
  endtask
  // Clock is 5 cycles low, 3 high; n bits of tx, MSB first; pause before bit hb
  task automatic xfer(input logic [31:0] tx, input int n, input int hb, output logic [31:0] rx);
    rx = '0;
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge clk);
      si <= tx[i];
      if (i == hb) begin
        hold_n <= 1'b0;
        cyc(3);
        sck <= 1'b1;
        si <= ~tx[i];
        cyc(3);
        sck <= 1'b0;
        si <= tx[i];
        cyc(3);
        hold_n <= 1'b1;
        // Room for the resynchronised release to drive the output again
        cyc(2);
      end
      cyc(4);
      rx[i] = so_oe ? so_o : 1'bx;
      sck <= 1'b1;
      cyc(3);
      sck <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// ==== sshp_port_test.sv ====
// Self-checking bench for the select/hold port
`timescale 1ns/1ps
`default_nettype none
module sshp_port_test
  import sshp_pkg::*;
;
  logic        clk, rstn, cs_n, sck, si, hold_n, so_o, so_oe, wr_valid, wr_ready, rd_req, busy;
  sshp_wreq_t  wr_req;
  sshp_wreq_t  wq[$];
  logic [14:0] rd_addr;
  logic [7:0]  rd_data, status_q;
  logic [31:0] rx;
  int          fail_count, n_compared, cycles;
  sshp_port #(.FIFO_DEPTH(SSHP_FIFO_D)) uut (.clk(clk), .rstn(rstn), .cs_n(cs_n), .sck(sck), .si(si),
    .hold_n(hold_n), .so_o(so_o), .so_oe(so_oe), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_req(wr_req),
    .rd_req(rd_req), .rd_addr(rd_addr), .rd_data(rd_data), .status_q(status_q), .busy(busy));
  sshp_host host (.clk(clk), .so_o(so_o), .so_oe(so_oe), .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n));
  // Memory answers one cycle after the request with a pattern of its address
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (wr_valid && wr_ready) wq.push_back(wr_req);
    if (rd_req) rd_data <= rd_addr[7:0] ^ 8'hA5;
    if (cycles == 30000) begin
      fail_count++;
      give_verdict();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Burst of eight bytes across the top address while the far side stalls
  task automatic t_write();
    wr_ready <= 1'b0;
    host.sel(1'b0);
    host.xfer(32'h02FFFC, 24, -1, rx);
    for (int k = 0; k < 8; k++) host.xfer(32'h10 + k, 8, -1, rx);
    host.sel(1'b1);
    chk(busy, 1'b1);
    wr_ready <= 1'b1;
    host.cyc(30);
    chk(wq.size(), 8);
    for (int k = 0; k < 8; k++) chk(wq[k], {15'h7FFC + 15'(k), 8'h10 + 8'(k)});
    chk(busy, 1'b0);
    $display("write test done");
  endtask
  // Read of two bytes, paused in mid-address and again in mid-data
  task automatic t_read();
    host.sel(1'b0);
    host.xfer(32'h038040, 24, 5, rx);
    host.xfer(32'h0, 16, 11, rx);
    host.sel(1'b1);
    chk(rx[15:8], 8'h40 ^ 8'hA5);
    chk(rx[7:0], 8'h41 ^ 8'hA5);
    chk(so_oe, 1'b0);
    $display("read test done");
  endtask
  // Status write, read back, partial frame, unknown opcode
  task automatic t_status();
    host.sel(1'b0);
    host.xfer(32'h0140, 16, -1, rx);
    host.sel(1'b1);
    chk(status_q, 8'h40);
    host.sel(1'b0);
    host.xfer(32'h0500, 16, -1, rx);
    host.sel(1'b1);
    chk(rx[7:0], 8'h40);
    host.sel(1'b0);
    host.xfer(32'h0, 4, -1, rx);
    host.sel(1'b1);
    host.sel(1'b0);
    host.xfer(32'h0180, 16, -1, rx);
    host.sel(1'b1);
    chk(status_q, 8'h80);
    host.sel(1'b0);
    host.xfer(32'hFF0100, 24, -1, rx);
    host.sel(1'b1);
    chk(status_q, 8'h80);
    $display("status test done");
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    rstn = 1'b0;
    wr_ready = 1'b1;
    rd_data = 8'h00;
    cycles = 0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    host.cyc(4);
    chk(status_q, SSHP_STAT_RST);
    chk(so_oe, 1'b0);
    t_write();
    t_read();
    t_status();
    give_verdict();
  end
endmodule
`default_nettype wire
